// ===== rtl/por_backup_switchover_ctrl.sv
`timescale 1ns/1ps
module por_backup_switchover_ctrl #(
	parameter int unsigned REFRESH_CYCLES = pwr_seq_pkg::REFRESH_CYC,
	parameter int unsigned DSM_SETTLE_CYCLES = pwr_seq_pkg::DSM_SETTLE_CYC,
	parameter int unsigned LSM_SETTLE_CYCLES = pwr_seq_pkg::LSM_SETTLE_CYC,
	parameter int unsigned DEBOUNCE_CYCLES = pwr_seq_pkg::DEBOUNCE_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire pwr_seq_pkg::supply_cmp_t supply_cmp,
	input wire logic supply_drop,
	input wire logic [7:0] nv_fout_cfg,
	input wire logic [7:0] nv_backup_cfg,
	input wire logic event_input,
	input wire logic other_irq,
	input wire logic clkout_req,
	output logic volatile_init,
	output logic on_backup,
	output logic backup_draw_en,
	output logic host_port_rst,
	output logic host_port_oe_allow,
	output logic clkout_pin,
	output logic event_out,
	output logic timestamp_trig,
	output logic clkout_auto_en,
	output logic interrupt_out_n
);
	import pwr_seq_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Bus slave

	logic addr_ph;
	logic [7:0] idx;
	logic wr_q;
	logic [7:0] widx_q;
	logic [31:0] rd_d;
	logic [31:0] hrdata_q;
	logic wr_status;
	logic wr_ctrl;
	logic wr_fout;
	logic wr_backup;

	// Index from the word address; lanes above 8 bits read as zero
	assign addr_ph = hsel & htrans[1] & hready;
	assign idx = haddr[9:2];
	assign wr_status = wr_q & (widx_q == IDX_STATUS);
	assign wr_ctrl = wr_q & (widx_q == IDX_CTRL);
	assign wr_fout = wr_q & (widx_q == IDX_FOUT_CFG);
	assign wr_backup = wr_q & (widx_q == IDX_BACKUP_CFG);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	// Address phase captured; data staged so hrdata comes from a flop
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_q <= 1'b0;
			widx_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
		end else if (ce) begin
			wr_q <= addr_ph & hwrite;
			widx_q <= idx;
			if (addr_ph & ~hwrite) begin
				hrdata_q <= rd_d;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power-up refresh and mirrors

	logic [31:0] ref_cnt_q;
	logic busy_q;
	logic [7:0] fout_cfg_q;
	backup_cfg_t backup_cfg_q;
	logic [1:0] ctrl_q;
	logic refresh_done;

	assign refresh_done = busy_q & (ref_cnt_q == REFRESH_CYCLES - 1);
	assign volatile_init = sys_rst;

	// Busy spans the whole refresh; Fout and backup writes during it are overwritten at its end, control writes are kept
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ref_cnt_q <= 32'h0000_0000;
			busy_q <= 1'b1;
			fout_cfg_q <= FOUT_CFG_RST;
			backup_cfg_q <= BACKUP_CFG_RST;
			ctrl_q <= CTRL_RST;
		end else if (ce) begin
			if (busy_q) begin
				ref_cnt_q <= ref_cnt_q + 32'h0000_0001;
			end
			if (refresh_done) begin
				busy_q <= 1'b0;
				fout_cfg_q <= nv_fout_cfg;
				backup_cfg_q <= nv_backup_cfg;
			end else begin
				if (wr_fout) begin
					fout_cfg_q <= hwdata[7:0];
				end
				if (wr_backup) begin
					backup_cfg_q <= hwdata[7:0];
				end
			end
			if (wr_ctrl) begin
				ctrl_q <= hwdata[1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Comparator synchronisers

	supply_cmp_t cmp_m_q;
	supply_cmp_t cmp_q;

	// Two flops; only the second stage feeds decisions
	// They sample through reset, so the first decision after release sees real rails
	always_ff @(posedge clk) begin
		if (ce) begin
			cmp_m_q <= supply_cmp;
			cmp_q <= cmp_m_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Effective mode with settle delay

	sw_mode_t prog_mode;
	sw_mode_t eff_mode_q;
	logic [31:0] set_cnt_q;
	logic [31:0] set_lim;
	logic from_idle;
	logic mode_chg;
	logic settle_done;

	assign prog_mode = sw_mode_t'(backup_cfg_q.switchover_mode_select);
	assign from_idle = (eff_mode_q == MODE_OFF) | (eff_mode_q == MODE_STANDBY);
	assign mode_chg = prog_mode != eff_mode_q;
	// Waking the comparators needs time; other changes apply at once
	assign set_lim = (prog_mode == MODE_LEVEL) ? LSM_SETTLE_CYCLES - 1 : DSM_SETTLE_CYCLES - 1;
	assign settle_done = ~from_idle | (prog_mode == MODE_OFF) | (prog_mode == MODE_STANDBY)
		| (set_cnt_q >= set_lim);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			eff_mode_q <= MODE_OFF;
			set_cnt_q <= 32'h0000_0000;
		end else if (ce) begin
			if (mode_chg & settle_done) begin
				eff_mode_q <= prog_mode;
				set_cnt_q <= 32'h0000_0000;
			end else if (mode_chg) begin
				set_cnt_q <= set_cnt_q + 32'h0000_0001;
			end else begin
				set_cnt_q <= 32'h0000_0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power state machine

	pwr_state_t ps_q;
	pwr_state_t ps_d;
	logic want_bk;
	logic [31:0] deb_cnt_q;
	logic deb_done;
	logic first_q;

	// Supply selection per mode
	assign want_bk = ((eff_mode_q == MODE_DIRECT) & cmp_q.main_lt_backup)
		| ((eff_mode_q == MODE_LEVEL) & cmp_q.main_lt_backup
		& cmp_q.main_lt_thresh & cmp_q.backup_gt_thresh);
	assign deb_done = deb_cnt_q == DEBOUNCE_CYCLES - 1;

	always_comb begin
		ps_d = ps_q;
		case (ps_q)
			PS_MAIN: begin
				if (first_q & ~cmp_q.main_present) begin
					ps_d = PS_STANDBY;
				end else if ((eff_mode_q == MODE_STANDBY) & ~cmp_q.main_present) begin
					ps_d = PS_STANDBY;
				end else if (want_bk) begin
					ps_d = PS_BACKUP;
				end
			end
			PS_BACKUP: begin
				if (eff_mode_q == MODE_OFF) begin
					ps_d = PS_MAIN;
				end else if (deb_done) begin
					ps_d = PS_MAIN;
				end
			end
			PS_STANDBY: begin
				if (cmp_q.main_present) begin
					ps_d = PS_MAIN;
				end
			end
			default: begin
				ps_d = PS_MAIN;
			end
		endcase
	end

	// Debounce restarts whenever main looks bad again, rejecting oscillation
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ps_q <= PS_MAIN;
			deb_cnt_q <= 32'h0000_0000;
			first_q <= 1'b1;
		end else if (ce) begin
			ps_q <= ps_d;
			first_q <= 1'b0;
			if ((ps_q == PS_BACKUP) & ~want_bk & ~deb_done) begin
				deb_cnt_q <= deb_cnt_q + 32'h0000_0001;
			end else begin
				deb_cnt_q <= 32'h0000_0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Flags and interrupt

	logic plf_q;
	logic plf_irq_q;
	logic swf_q;
	logic bk_enter;
	logic bk_leave;
	logic plf_clr;
	logic swf_clr;
	logic ts_q;
	logic auto_q;

	assign bk_enter = (ps_q != PS_BACKUP) & (ps_d == PS_BACKUP);
	assign bk_leave = (ps_q == PS_BACKUP) & (ps_d == PS_MAIN);
	assign plf_clr = wr_status & ~hwdata[ST_PLF];
	assign swf_clr = wr_status & ~hwdata[ST_SWF] & (ps_q != PS_BACKUP);

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			plf_q <= 1'b1;
			plf_irq_q <= 1'b0;
			swf_q <= 1'b0;
			ts_q <= 1'b0;
			auto_q <= 1'b0;
		end else if (ce) begin
			if (supply_drop) begin
				plf_q <= 1'b1;
			end else if (plf_clr) begin
				plf_q <= 1'b0;
			end
			if (supply_drop & ~plf_q) begin
				plf_irq_q <= 1'b1;
			end else if (plf_clr) begin
				plf_irq_q <= 1'b0;
			end
			if (bk_enter) begin
				swf_q <= 1'b1;
			end else if (swf_clr) begin
				swf_q <= 1'b0;
			end
			ts_q <= bk_enter & ctrl_q[CT_TS_ON_BACKUP];
			auto_q <= bk_leave & ctrl_q[CT_CLKOUT_AUTO];
		end
	end

	logic sw_irq;
	logic pl_irq;

	// Interrupt output is a combination of enabled sources; it stays live on backup
	assign sw_irq = swf_q & backup_cfg_q.switchover_irq_enable;
	assign pl_irq = plf_irq_q & fout_cfg_q[FC_PLIE];
	assign interrupt_out_n = ~(sw_irq | pl_irq | other_irq);

	////////////////////////////////////////////////////////////////////////////
	// Pin control

	assign on_backup = ps_q == PS_BACKUP;
	assign backup_draw_en = ps_q != PS_STANDBY;
	assign host_port_rst = on_backup;
	assign host_port_oe_allow = ~on_backup;
	assign clkout_pin = clkout_req & ~on_backup;
	assign event_out = event_input;
	assign timestamp_trig = ts_q;
	assign clkout_auto_en = auto_q;

	// Read mux; flag reads 0 whenever switchover is disabled
	logic [7:0] status_v;
	assign status_v = {3'h0, ps_q == PS_STANDBY, on_backup,
		swf_q & (eff_mode_q != MODE_OFF), plf_q, busy_q};
	always_comb begin
		rd_d = 32'h0000_0000;
		case (idx)
			IDX_STATUS: rd_d = {24'h00_0000, status_v};
			IDX_CTRL: rd_d = {30'h0000_0000, ctrl_q};
			IDX_FOUT_CFG: rd_d = {24'h00_0000, fout_cfg_q};
			IDX_BACKUP_CFG: rd_d = {24'h00_0000, backup_cfg_q};
			default: rd_d = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	sequence s_return_wait;
		(ps_q == PS_BACKUP) & ~want_bk & ce & (eff_mode_q != MODE_OFF);
	endsequence

	a_busy_refresh: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(busy_q) |-> fout_cfg_q == $past(nv_fout_cfg))
		else $error("mirror not loaded at end of refresh");
	a_busy_first: assert property (@(posedge clk) disable iff (sys_rst)
		busy_q & (ref_cnt_q < REFRESH_CYCLES - 1) |=> busy_q)
		else $error("busy dropped early");
	a_plf_sticky: assert property (@(posedge clk) disable iff (sys_rst)
		plf_q & ~plf_clr |=> plf_q)
		else $error("power loss flag lost");
	a_disabled_main: assert property (@(posedge clk) disable iff (sys_rst)
		ce & (eff_mode_q == MODE_OFF) & ~first_q |=> ps_q != PS_BACKUP)
		else $error("backup used while disabled");
	a_direct_enter: assert property (@(posedge clk) disable iff (sys_rst)
		ce & ~first_q & (ps_q == PS_MAIN) & (eff_mode_q == MODE_DIRECT)
		& cmp_q.main_lt_backup |=> on_backup)
		else $error("direct switch missed");
	a_level_hold: assert property (@(posedge clk) disable iff (sys_rst)
		(ps_q == PS_MAIN) & (eff_mode_q == MODE_LEVEL) & ~cmp_q.main_lt_thresh |=> ~on_backup)
		else $error("level switch above threshold");
	a_return_deb: assert property (@(posedge clk) disable iff (sys_rst)
		on_backup & $fell(want_bk) ##1 s_return_wait[*8] |=> on_backup)
		else $error("return not debounced");
	a_flag_irq: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(on_backup) & backup_cfg_q.switchover_irq_enable |-> swf_q ##0 ~interrupt_out_n)
		else $error("switchover flag or interrupt missing");
	a_backup_pins: assert property (@(posedge clk) disable iff (sys_rst)
		on_backup |-> host_port_rst & ~host_port_oe_allow & ~clkout_pin)
		else $error("pins active on backup");
	a_swf_keep: assert property (@(posedge clk) disable iff (sys_rst)
		ce & on_backup & swf_q |=> swf_q)
		else $error("switchover flag cleared on backup");
endmodule

// ===== rtl/pwr_seq_pkg.sv
package pwr_seq_pkg;
	// Timing, 200 MHz clock
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned REFRESH_TIME_NS = 66_000_000;
	localparam int unsigned DSM_SETTLE_NS = 2_000_000;
	localparam int unsigned LSM_SETTLE_NS = 15_625_000;
	localparam int unsigned DEBOUNCE_MIN_NS = 122_000;
	localparam int unsigned DEBOUNCE_MAX_NS = 183_000;
	// Least times round up, longest times round down
	localparam int unsigned REFRESH_CYC = (REFRESH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DSM_SETTLE_CYC = DSM_SETTLE_NS / CLK_PERIOD_NS;
	localparam int unsigned LSM_SETTLE_CYC = LSM_SETTLE_NS / CLK_PERIOD_NS;
	localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTRL = 8'h00;
	localparam logic [7:0] IDX_STATUS = 8'h0E;
	localparam logic [7:0] IDX_FOUT_CFG = 8'h35;
	localparam logic [7:0] IDX_BACKUP_CFG = 8'h37;

	// Status register bits
	localparam int unsigned ST_BUSY = 0;
	localparam int unsigned ST_PLF = 1;
	localparam int unsigned ST_SWF = 2;
	localparam int unsigned ST_ONBK = 3;
	localparam int unsigned ST_STBY = 4;
	// Control register bits
	localparam int unsigned CT_TS_ON_BACKUP = 0;
	localparam int unsigned CT_CLKOUT_AUTO = 1;
	// Fout configuration bit
	localparam int unsigned FC_PLIE = 3;

	// Reset values of the mirrors
	localparam logic [7:0] FOUT_CFG_RST = 8'hC0;
	localparam logic [7:0] BACKUP_CFG_RST = 8'h10;
	localparam logic [1:0] CTRL_RST = 2'h0;

	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_DIRECT = 2'b01,
		MODE_STANDBY = 2'b10,
		MODE_LEVEL = 2'b11
	} sw_mode_t;

	// Backup configuration byte layout
	typedef struct packed {
		logic [2:0] rsvd;
		logic fast_edge_detect_enable;
		logic [1:0] switchover_mode_select;
		logic switchover_irq_enable;
		logic spare;
	} backup_cfg_t;

	// Supply comparator results
	typedef struct packed {
		logic main_present;
		logic main_lt_backup;
		logic main_lt_thresh;
		logic backup_gt_thresh;
	} supply_cmp_t;

	// Power state machine
	typedef enum logic [2:0] {
		PS_MAIN = 3'b001,
		PS_BACKUP = 3'b010,
		PS_STANDBY = 3'b100
	} pwr_state_t;
endpackage

// ===== tb/supply_model.sv
`timescale 1ns/1ps
// Far-side rails seen through the supply comparators
module supply_model #(
	parameter logic [7:0] THRESH = 8'h20
) (
	input wire logic clk,
	input wire logic [7:0] main_lvl,
	input wire logic [7:0] bak_lvl,
	output pwr_seq_pkg::supply_cmp_t cmp
);
	import pwr_seq_pkg::*;
	// Comparators settle just after the edge; main at zero means removed
	always @(posedge clk) begin
		cmp <= '{main_lvl != 8'h00, main_lvl < bak_lvl, main_lvl < THRESH, bak_lvl > THRESH};
	end
endmodule

// ===== tb/por_backup_switchover_ctrl_tb.sv
`timescale 1ns/1ps
module por_backup_switchover_ctrl_tb;
	import pwr_seq_pkg::*;
	localparam logic [7:0] T = 8'h20;
	logic clk, sys_rst, hsel, hwrite, supply_drop, event_input, clkout_req, ob;
	logic ce, oirq;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans, m;
	logic hreadyout, hresp, on_backup, draw_en, hp_rst, hp_oe, clkout_pin, event_out;
	logic ts_trig, ck_auto, irq_n;
	logic [7:0] nv_fout, nv_bak, main_lvl, bak_lvl;
	supply_cmp_t cmp;
	int seed, mismatches, n_tests, n_ts, n_ck, ts0, ck0;

	////////////////////////////////////////////////////////////////
	// Shortened counts keep the run brief
	por_backup_switchover_ctrl #(.REFRESH_CYCLES(20), .DSM_SETTLE_CYCLES(10),
		.LSM_SETTLE_CYCLES(15), .DEBOUNCE_CYCLES(12)) uut (
		.clk(clk), .sys_rst(sys_rst), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.supply_cmp(cmp), .supply_drop(supply_drop), .nv_fout_cfg(nv_fout),
		.nv_backup_cfg(nv_bak), .event_input(event_input), .other_irq(oirq),
		.clkout_req(clkout_req), .volatile_init(), .on_backup(on_backup),
		.backup_draw_en(draw_en), .host_port_rst(hp_rst), .host_port_oe_allow(hp_oe),
		.clkout_pin(clkout_pin), .event_out(event_out), .timestamp_trig(ts_trig),
		.clkout_auto_en(ck_auto), .interrupt_out_n(irq_n));
	supply_model #(.THRESH(T)) rails (.clk(clk), .main_lvl(main_lvl), .bak_lvl(bak_lvl),
		.cmp(cmp));

	////////////////////////////////////////////////////////////////
	// Clock, random event pin and pulse counting
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		event_input <= 1'($random(seed));
		n_ts <= n_ts + int'(ts_trig === 1'b1);
		n_ck <= n_ck + int'(ck_auto === 1'b1);
	end

	// Backup wanted for a mode and rail pair
	function automatic logic want(input logic [1:0] md, input logic [7:0] mn, input logic [7:0] bk);
		case (md)
			2'b01: return mn < bk;
			2'b11: return mn < bk && mn < T && bk > T;
			default: return 1'b0;
		endcase
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			mismatches++;
		end
	endtask

	// One single transfer; request held until hready is seen high
	task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {22'h0, idx, 2'b00};
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, idx, d, x);
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, idx, 32'h0, x);
		chk(x, exp);
	endtask

	// Checks land after the edge's updates have settled
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// A hang is cut well beyond the few hundred cycles needed
	initial begin
		#25000;
		mismatches++;
		tally_and_finish();
	end

	////////////////////////////////////////////////////////////////
	initial begin
		seed = 44;
		{mismatches, n_tests, n_ts, n_ck} = '0;
		{hsel, hwrite, supply_drop, clkout_req, event_input} = '0;
		ce = 1'b1;
		oirq = 1'b0;
		{haddr, hwdata, htrans} = '0;
		sys_rst = 1'b1;
		main_lvl = 8'h80;
		bak_lvl = 8'h40;
		nv_fout = 8'($random(seed));
		r = $random(seed);
		nv_bak = {3'b000, 1'b1, 2'b00, r[1:0]};
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		rdc(IDX_STATUS, 32'h0000_0003);
		rdc(IDX_FOUT_CFG, 32'h0000_00C0);
		rdc(IDX_BACKUP_CFG, 32'h0000_0010);
		settle(25);
		rdc(IDX_STATUS, 32'h0000_0002);
		rdc(IDX_FOUT_CFG, {24'h0, nv_fout});
		rdc(IDX_BACKUP_CFG, {24'h0, nv_bak});
		$display("Test refresh done");
		wr(IDX_STATUS, 32'h0);
		rdc(IDX_STATUS, 32'h0);
		wr(IDX_FOUT_CFG, 32'h0000_0008);
		@(posedge clk) supply_drop <= 1'b1;
		@(posedge clk) supply_drop <= 1'b0;
		settle(3);
		chk(32'(irq_n), 32'h0);
		rdc(IDX_STATUS, 32'h0000_0002);
		wr(IDX_STATUS, 32'h0);
		settle(2);
		chk(32'(irq_n), 32'h1);
		// Other sources reach the pin; a drop while frozen must leave no trace
		@(posedge clk) oirq <= 1'b1;
		settle(1);
		chk(32'(irq_n), 32'h0);
		@(posedge clk) oirq <= 1'b0;
		ce <= 1'b0;
		supply_drop <= 1'b1;
		@(posedge clk) ce <= 1'b1;
		supply_drop <= 1'b0;
		settle(1);
		chk(32'(irq_n), 32'h1);
		rdc(IDX_STATUS, 32'h0);
		$display("Test power loss done");
		for (int i = 0; i < 4; i++) begin
			m = i[1:0];
			wr(IDX_CTRL, 32'h0000_0003);
			wr(IDX_BACKUP_CFG, 32'h0000_0010);
			ts0 = n_ts;
			ck0 = n_ck;
			@(posedge clk) main_lvl <= (m == 2'b10) ? 8'h00 : (m == 2'b11) ? 8'h30 : 8'h10;
			clkout_req <= 1'b1;
			wr(IDX_BACKUP_CFG, {24'h0, 3'b000, 1'b1, m, 2'b10});
			settle(23);
			ob = want(m, main_lvl, bak_lvl);
			chk(32'(on_backup), 32'(ob));
			if (m == 2'b11) begin
				@(posedge clk) main_lvl <= 8'h10;
				settle(5);
				ob = want(m, main_lvl, bak_lvl);
				chk(32'(on_backup), 32'(ob));
			end
			if (m == 2'b10) begin
				chk(32'(draw_en), 32'h0);
				rdc(IDX_STATUS, 32'h0000_0010);
			end
			if (m == 2'b00) begin
				rdc(IDX_STATUS, 32'h0);
			end
			if (ob) begin
				chk(32'(clkout_pin), 32'h0);
				chk(32'({hp_rst, hp_oe}), 32'h2);
				chk(32'(event_out), 32'(event_input));
				chk(32'(irq_n), 32'h0);
				chk(n_ts - ts0, 32'h1);
				wr(IDX_STATUS, 32'h0);
				rdc(IDX_STATUS, 32'h0000_000C);
				@(posedge clk) main_lvl <= 8'h80;
				settle(8);
				chk(32'(on_backup), 32'h1);
				settle(12);
				chk(32'(on_backup), 32'h0);
				chk(32'(hp_rst), 32'h0);
				chk(32'(clkout_pin), 32'h1);
				chk(n_ck - ck0, 32'h1);
				chk(32'(irq_n), 32'h0);
				wr(IDX_STATUS, 32'h0);
				settle(2);
				chk(32'(irq_n), 32'h1);
			end
			@(posedge clk) main_lvl <= 8'h80;
			settle(5);
			chk(32'(draw_en), 32'h1);
			$display("Test mode %0d done", i);
		end
		@(posedge clk) sys_rst <= 1'b1;
		main_lvl <= 8'h00;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		settle(4);
		chk(32'(draw_en), 32'h0);
		rdc(IDX_STATUS, 32'h0000_0013);
		$display("Test backup power-up done");
		tally_and_finish();
	end
endmodule
